/* File: design/bpd_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bpd_regs.svh"

module bpd_supervisor
  import bpd_pkg::*;
#(
  // Clock cycles per 0.1 s; shorten in simulation.
  parameter int unsigned TENTH_CYCLES =
    (`BPD_TENTH_MS * 1000000) / `BPD_CLK_PERIOD_NS
)(
  // Clock and reset.
  input  wire logic           clk_sys_i,
  input  wire logic           arst_n_i,
  // Parameter access.
  input  wire bpd_param_req_s param_req_i,
  output logic [15:0]         param_rdata_o,
  output logic                param_ack_o,
  output logic                param_err_o,
  // Measurements and conditions.
  input  wire bpd_meas_s      meas_i,
  input  wire logic           discharge_overcurrent_i,
  input  wire logic           charge_overcurrent_i,
  input  wire logic           high_discharge_i,
  input  wire logic           cell_comm_ok_i,
  input  wire logic           charger_connected_i,
  input  wire logic           charge_finished_i,
  input  wire logic           contactor_prot_en_i,
  input  wire logic           prot_clear_i,
  // Results.
  output bpd_flags_s          flags_o,
  output logic                contactor_open_o,
  output logic                charge_stop_o,
  output logic                fault_o,
  output logic                climate_stop_o,
  output logic                charge_restart_o,
  output logic                soc_load_o,
  output logic [7:0]          soc_load_value_o
);

  // ----------------------------------------------------------------------
  // Whole state of the block.
  // ----------------------------------------------------------------------

  typedef struct packed {
    logic [31:0]                 pre;         // Cycle prescaler.
    logic [3:0]                  tenths;      // Tenths within a second.
    logic                        tick_tenth;  // 0.1 s strobe.
    logic                        tick_sec;    // 1 s strobe.
    bpd_chan_s [BPD_NCH-1:0]     ch;          // Debounce channels.
    bpd_par_t                    par;         // Byte parameters.
    logic [15:0]                 climate_min; // Signed SOC floor.
    logic                        lv_seen;     // Warning level seen.
    logic                        restart_seen; // Restart level seen.
    bpd_flags_s                  flags;
    logic                        contactor_open;
    logic                        charge_stop;
    logic                        fault;
    logic                        climate_stop;
    logic                        charge_restart;
    logic                        soc_load;
    logic [7:0]                  soc_load_value;
    logic [15:0]                 rdata;
    logic                        ack;
    logic                        err;
  } bpd_state_s;

  bpd_state_s state;       // Registered state.
  bpd_state_s next_state;  // Next state.

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------

  // Maps a parameter offset to its storage slot; all ones means unmapped.
  // The delay and release block is contiguous, so it is one subtraction.
  function automatic logic [5:0] bpd_index(input logic [15:0] addr);
    logic [15:0] rel;
    rel = addr - `BPD_OFF_UV_ACT_DLY;
    if (addr == `BPD_OFF_UV_ACT_THR)
      return 6'h00;
    else if (addr == `BPD_OFF_OV_ACT_THR)
      return 6'h01;
    else if (addr == `BPD_OFF_OH_ACT_THR)
      return 6'h02;
    else if (addr == `BPD_OFF_LV_ACT_THR)
      return 6'h03;
    else if (addr == `BPD_OFF_HT_ACT_THR)
      return 6'h04;
    else if (addr == `BPD_OFF_RESTART_V)
      return 6'h05;
    else if (addr == `BPD_OFF_SOC_WARN)
      return 6'h06;
    else if (addr >= `BPD_OFF_UV_ACT_DLY && addr <= `BPD_OFF_HTR_REL_THR)
      return 6'(rel[5:0] + 6'h07);
    else
      return 6'h3F;
  endfunction

  // Reads one byte parameter by its offset.
  function automatic logic [7:0] bpd_par(input bpd_par_t par, input logic [15:0] addr);
    logic [5:0] idx;
    idx = bpd_index(addr);
    return par[idx[4:0]];
  endfunction

  // ----------------------------------------------------------------------
  // Channel conditions.
  // ----------------------------------------------------------------------

  // Condition that arms activation, and condition that counts as absent.
  // Codes of one kind share offset and step, so they compare directly.
  logic [BPD_NCH-1:0] act_cond;   // Condition present.
  logic [BPD_NCH-1:0] rel_cond;   // Condition absent (release side).
  logic [BPD_NCH-1:0][7:0] act_dly; // Activation delay, 0.1 s units.
  logic [BPD_NCH-1:0][7:0] rel_dly; // Release delay, 1 s units.

  // Builds the per-channel table from measurements and parameters.
  always_comb
  begin
    // Under-voltage: min cell at or below activate, released at or above own level.
    act_cond[0] = meas_i.min_cell_v <= bpd_par(state.par, `BPD_OFF_UV_ACT_THR);
    rel_cond[0] = meas_i.min_cell_v >= bpd_par(state.par, `BPD_OFF_UV_REL_THR);
    act_dly[0]  = bpd_par(state.par, `BPD_OFF_UV_ACT_DLY);
    rel_dly[0]  = bpd_par(state.par, `BPD_OFF_UV_REL_DLY);
    // Over-voltage: max cell at or above activate.
    act_cond[1] = meas_i.max_cell_v >= bpd_par(state.par, `BPD_OFF_OV_ACT_THR);
    rel_cond[1] = meas_i.max_cell_v <= bpd_par(state.par, `BPD_OFF_OV_REL_THR);
    act_dly[1]  = bpd_par(state.par, `BPD_OFF_OV_ACT_DLY);
    rel_dly[1]  = bpd_par(state.par, `BPD_OFF_OV_REL_DLY);
    // Module over-heat.
    act_cond[2] = meas_i.max_module_t >= bpd_par(state.par, `BPD_OFF_OH_ACT_THR);
    rel_cond[2] = meas_i.max_module_t <= bpd_par(state.par, `BPD_OFF_OH_REL_THR);
    act_dly[2]  = bpd_par(state.par, `BPD_OFF_OH_ACT_DLY);
    rel_dly[2]  = bpd_par(state.par, `BPD_OFF_OH_REL_DLY);
    // Discharge over-current, judged outside this block.
    act_cond[3] = discharge_overcurrent_i;
    rel_cond[3] = !discharge_overcurrent_i;
    act_dly[3]  = bpd_par(state.par, `BPD_OFF_DOC_ACT_DLY);
    rel_dly[3]  = bpd_par(state.par, `BPD_OFF_DOC_REL_DLY);
    // Charge over-current.
    act_cond[4] = charge_overcurrent_i;
    rel_cond[4] = !charge_overcurrent_i;
    act_dly[4]  = bpd_par(state.par, `BPD_OFF_COC_ACT_DLY);
    rel_dly[4]  = bpd_par(state.par, `BPD_OFF_COC_REL_DLY);
    // Cell communication missing.
    act_cond[5] = !cell_comm_ok_i;
    rel_cond[5] = cell_comm_ok_i;
    act_dly[5]  = bpd_par(state.par, `BPD_OFF_COMM_ACT_DLY);
    rel_dly[5]  = bpd_par(state.par, `BPD_OFF_COMM_REL_DLY);
    // Low cell voltage reduction shares the warning threshold.
    act_cond[6] = meas_i.min_cell_v <= bpd_par(state.par, `BPD_OFF_LV_ACT_THR);
    rel_cond[6] = meas_i.min_cell_v >= bpd_par(state.par, `BPD_OFF_LVR_REL_THR);
    act_dly[6]  = bpd_par(state.par, `BPD_OFF_LVR_ACT_DLY);
    rel_dly[6]  = bpd_par(state.par, `BPD_OFF_LVR_REL_DLY);
    // High module temperature reduction.
    act_cond[7] = meas_i.max_module_t >= bpd_par(state.par, `BPD_OFF_HT_ACT_THR);
    rel_cond[7] = meas_i.max_module_t <= bpd_par(state.par, `BPD_OFF_HTR_REL_THR);
    act_dly[7]  = bpd_par(state.par, `BPD_OFF_HTR_ACT_DLY);
    rel_dly[7]  = bpd_par(state.par, `BPD_OFF_HTR_REL_DLY);
    // High discharge current reduction.
    act_cond[8] = high_discharge_i;
    rel_cond[8] = !high_discharge_i;
    act_dly[8]  = bpd_par(state.par, `BPD_OFF_HDR_ACT_DLY);
    rel_dly[8]  = bpd_par(state.par, `BPD_OFF_HDR_REL_DLY);
  end

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------

  // One process computes every next value of the block.
  always_comb
  begin
    logic [5:0] idx;
    logic       lv_now;
    logic       restart_now;
    idx         = bpd_index(param_req_i.addr);
    lv_now      = 1'b0;
    restart_now = 1'b0;
    next_state  = state;

    // Tick strobes: a tenth every TENTH_CYCLES, a second every ten tenths.
    next_state.tick_tenth = 1'b0;
    next_state.tick_sec   = 1'b0;
    if (state.pre >= 32'(TENTH_CYCLES - 1))
    begin
      next_state.pre        = 32'h0000_0000;
      next_state.tick_tenth = 1'b1;
      if (state.tenths >= `BPD_TENTHS_PER_SEC - 4'h1)
      begin
        next_state.tenths   = 4'h0;
        next_state.tick_sec = 1'b1;
      end
      else
      begin
        next_state.tenths = state.tenths + 4'h1;
      end
    end
    else
    begin
      next_state.pre = state.pre + 32'h0000_0001;
    end

    // Debounce channels. A tick may arrive early in the first interval, so
    // the real wait lies between delay-1 and delay units; zero acts at once.
    for (int i = 0; i < BPD_NCH; i++)
    begin
      case (state.ch[i].state)
        BPD_INACTIVE:
        begin
          if (!act_cond[i])
          begin
            // Condition gone before expiry: start over.
            next_state.ch[i].cnt = 8'h00;
          end
          else if (state.ch[i].cnt >= act_dly[i])
          begin
            next_state.ch[i].state = BPD_ACTIVE;
            next_state.ch[i].cnt   = 8'h00;
          end
          else if (state.tick_tenth)
          begin
            next_state.ch[i].cnt = state.ch[i].cnt + 8'h01;
          end
        end
        BPD_ACTIVE:
        begin
          if (!rel_cond[i])
          begin
            // Condition back before expiry: start over.
            next_state.ch[i].cnt = 8'h00;
          end
          else if (state.ch[i].cnt >= rel_dly[i])
          begin
            next_state.ch[i].state = BPD_INACTIVE;
            next_state.ch[i].cnt   = 8'h00;
          end
          else if (state.tick_sec)
          begin
            next_state.ch[i].cnt = state.ch[i].cnt + 8'h01;
          end
        end
        default:
        begin
          next_state.ch[i] = '{state: BPD_INACTIVE, cnt: 8'h00};
        end
      endcase
      next_state.flags[i] = next_state.ch[i].state == BPD_ACTIVE;
    end

    // Synchronous clear of protections; parameters are left untouched.
    if (prot_clear_i)
    begin
      for (int i = 0; i < BPD_NCH; i++)
      begin
        next_state.ch[i] = '{state: BPD_INACTIVE, cnt: 8'h00};
      end
      next_state.flags = '0;
    end

    // Actions derived from the flags.
    next_state.contactor_open = contactor_prot_en_i &
                                (next_state.flags.uv | next_state.flags.ov);
    next_state.charge_stop    = next_state.flags.oh;
    next_state.fault          = next_state.flags.oh;

    // Climate control floor is a signed compare in 0.01 % units.
    next_state.climate_stop = $signed(meas_i.soc) < $signed(state.climate_min);

    // Charge restart fires once as the highest cell falls to the level.
    restart_now = charger_connected_i & charge_finished_i &
                  (meas_i.max_cell_v <= bpd_par(state.par, `BPD_OFF_RESTART_V));
    next_state.restart_seen   = restart_now;
    next_state.charge_restart = restart_now & !state.restart_seen;

    // SOC load fires once as the lowest cell reaches the warning level.
    lv_now = meas_i.min_cell_v <= bpd_par(state.par, `BPD_OFF_LV_ACT_THR);
    next_state.lv_seen  = lv_now;
    next_state.soc_load = lv_now & !state.lv_seen;
    if (lv_now & !state.lv_seen)
    begin
      next_state.soc_load_value = bpd_par(state.par, `BPD_OFF_SOC_WARN);
    end

    // Parameter access: one answer cycle per request, write wins over read.
    next_state.ack = param_req_i.wr | param_req_i.rd;
    next_state.err = 1'b0;
    if (param_req_i.wr)
    begin
      if (idx != 6'h3F)
      begin
        next_state.par[idx[4:0]] = param_req_i.wdata[7:0];
      end
      else if (param_req_i.addr == `BPD_OFF_CLIMATE_MIN_SOC)
      begin
        next_state.climate_min = param_req_i.wdata;
      end
      else
      begin
        // Unmapped or read-only: the write is dropped and flagged.
        next_state.err = 1'b1;
      end
    end
    else if (param_req_i.rd)
    begin
      if (idx != 6'h3F)
      begin
        next_state.rdata = {8'h00, state.par[idx[4:0]]};
      end
      else if (param_req_i.addr == `BPD_OFF_CLIMATE_MIN_SOC)
      begin
        next_state.rdata = state.climate_min;
      end
      else if (param_req_i.addr == `BPD_OFF_STATUS)
      begin
        next_state.rdata = {7'h00, state.flags};
      end
      else
      begin
        next_state.rdata = 16'h0000;
        next_state.err   = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------

  // Reset brings every channel inactive with cleared counters.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state             <= '0;
      state.par         <= {BPD_NPAR{`BPD_RST_PAR}};
      state.climate_min <= `BPD_RST_CLIMATE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------

  // All outputs come straight from the state register.
  assign param_rdata_o    = state.rdata;
  assign param_ack_o      = state.ack;
  assign param_err_o      = state.err;
  assign flags_o          = state.flags;
  assign contactor_open_o = state.contactor_open;
  assign charge_stop_o    = state.charge_stop;
  assign fault_o          = state.fault;
  assign climate_stop_o   = state.climate_stop;
  assign charge_restart_o = state.charge_restart;
  assign soc_load_o       = state.soc_load;
  assign soc_load_value_o = state.soc_load_value;

endmodule // bpd_supervisor
`default_nettype wire

/* File: design/bpd_regs.svh */
`ifndef BPD_REGS_SVH
`define BPD_REGS_SVH
// ----------------------------------------------------------------------
// Parameter offsets.
// ----------------------------------------------------------------------
`define BPD_OFF_UV_ACT_THR      16'h0004
`define BPD_OFF_OV_ACT_THR      16'h0005
`define BPD_OFF_OH_ACT_THR      16'h0006
`define BPD_OFF_LV_ACT_THR      16'h0008
`define BPD_OFF_HT_ACT_THR      16'h0015
`define BPD_OFF_RESTART_V       16'h001A
`define BPD_OFF_SOC_WARN        16'h0022
`define BPD_OFF_UV_ACT_DLY      16'h0025
`define BPD_OFF_UV_REL_DLY      16'h0026
`define BPD_OFF_OV_ACT_DLY      16'h0027
`define BPD_OFF_OV_REL_DLY      16'h0028
`define BPD_OFF_OH_ACT_DLY      16'h0029
`define BPD_OFF_OH_REL_DLY      16'h002A
`define BPD_OFF_DOC_ACT_DLY     16'h002B
`define BPD_OFF_DOC_REL_DLY     16'h002C
`define BPD_OFF_COC_ACT_DLY     16'h002D
`define BPD_OFF_COC_REL_DLY     16'h002E
`define BPD_OFF_COMM_ACT_DLY    16'h002F
`define BPD_OFF_COMM_REL_DLY    16'h0030
`define BPD_OFF_UV_REL_THR      16'h0031
`define BPD_OFF_OV_REL_THR      16'h0032
`define BPD_OFF_OH_REL_THR      16'h0033
`define BPD_OFF_LVR_ACT_DLY     16'h0034
`define BPD_OFF_LVR_REL_DLY     16'h0035
`define BPD_OFF_HTR_ACT_DLY     16'h0036
`define BPD_OFF_HTR_REL_DLY     16'h0037
`define BPD_OFF_HDR_ACT_DLY     16'h0038
`define BPD_OFF_HDR_REL_DLY     16'h0039
`define BPD_OFF_LVR_REL_THR     16'h003A
`define BPD_OFF_HTR_REL_THR     16'h003B
`define BPD_OFF_CLIMATE_MIN_SOC 16'h0118
`define BPD_OFF_STATUS          16'h0F00
// ----------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------
`define BPD_RST_PAR             8'h00
`define BPD_RST_CLIMATE         16'h0000
`define BPD_CLK_PERIOD_NS       20
`define BPD_TENTH_MS            100
`define BPD_TENTHS_PER_SEC      4'hA
`endif

/* File: design/bpd_pkg.sv */
package bpd_pkg;
  // Number of byte parameters held and number of debounced channels.
  localparam int unsigned BPD_NPAR = 30;
  localparam int unsigned BPD_NCH  = 9;
  typedef logic [BPD_NPAR-1:0][7:0] bpd_par_t;
  // Debounce state of one channel.
  typedef enum logic { BPD_INACTIVE, BPD_ACTIVE } bpd_chan_e;
  typedef struct packed {
    bpd_chan_e  state;
    logic [7:0] cnt;
  } bpd_chan_s;
  // Protection and reduction flags, bit 0 is under-voltage.
  typedef struct packed {
    logic hdr;
    logic htr;
    logic lvr;
    logic comm;
    logic coc;
    logic doc;
    logic oh;
    logic ov;
    logic uv;
  } bpd_flags_s;
  // Parameter access request over the serial protocol.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bpd_param_req_s;
  // Measurements, all in parameter encoding.
  typedef struct packed {
    logic [7:0]  min_cell_v;
    logic [7:0]  max_cell_v;
    logic [7:0]  max_module_t;
    logic [15:0] soc;
  } bpd_meas_s;
endpackage

/* File: verification/bpd_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the supervisor.
// ----------------------------------------------------------------------
module bpd_sva
  import bpd_pkg::*;
(
  // Clock and reset.
  input wire logic           clk_sys_i,
  input wire logic           arst_n_i,
  // Watched ports.
  input wire bpd_param_req_s param_req_i,
  input wire logic           param_ack_o,
  input wire logic           param_err_o,
  input wire bpd_flags_s     flags_o,
  input wire logic           contactor_open_o,
  input wire logic           charge_stop_o,
  input wire logic           fault_o,
  input wire logic           charge_restart_o,
  input wire logic           soc_load_o,
  input wire logic [7:0]     soc_load_value_o,
  input wire logic           discharge_overcurrent_i,
  input wire logic           charge_overcurrent_i,
  input wire logic           cell_comm_ok_i,
  input wire logic           prot_clear_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // A request and its one-cycle answer.
  sequence s_req; param_req_i.wr || param_req_i.rd; endsequence
  sequence s_ack; ##1 param_ack_o; endsequence
  property p_ack; s_req |-> s_ack; endproperty
  property p_no_ack; !(param_req_i.wr || param_req_i.rd) |=> !param_ack_o; endproperty
  property p_err; param_err_o |-> param_ack_o; endproperty
  property p_contact; contactor_open_o |-> (flags_o.uv || flags_o.ov); endproperty
  property p_stop; (charge_stop_o == flags_o.oh) && (fault_o == flags_o.oh); endproperty
  property p_doc_up; $rose(flags_o.doc) |-> $past(discharge_overcurrent_i); endproperty
  property p_coc_up; $rose(flags_o.coc) |-> $past(charge_overcurrent_i); endproperty
  property p_comm_up; $rose(flags_o.comm) |-> !$past(cell_comm_ok_i); endproperty
  // The doc flag may only drop once its condition is gone or a clear came in.
  property p_doc_dn;
    $fell(flags_o.doc) |-> (!$past(discharge_overcurrent_i) || $past(prot_clear_i));
  endproperty
  property p_clear; prot_clear_i |=> (flags_o == '0); endproperty
  property p_restart; charge_restart_o |=> !charge_restart_o; endproperty
  property p_soc_hold; !soc_load_o |-> $stable(soc_load_value_o); endproperty
  a_ack: assert property (p_ack) else $error("request without ack");
  a_no_ack: assert property (p_no_ack) else $error("ack without request");
  a_err: assert property (p_err) else $error("err without ack");
  a_contact: assert property (p_contact) else $error("contactor open without flag");
  a_stop: assert property (p_stop) else $error("charge stop differs from heat flag");
  a_doc_up: assert property (p_doc_up) else $error("doc rose without cause");
  a_coc_up: assert property (p_coc_up) else $error("coc rose without cause");
  a_comm_up: assert property (p_comm_up) else $error("comm rose while ok");
  a_doc_dn: assert property (p_doc_dn) else $error("doc fell with cause present");
  a_clear: assert property (p_clear) else $error("clear left a flag set");
  a_restart: assert property (p_restart) else $error("restart longer than a cycle");
  a_soc_hold: assert property (p_soc_hold) else $error("soc value moved alone");
endmodule // bpd_sva

bind bpd_supervisor bpd_sva u_sva (.clk_sys_i, .arst_n_i, .param_req_i, .param_ack_o,
  .param_err_o, .flags_o, .contactor_open_o, .charge_stop_o, .fault_o, .charge_restart_o,
  .soc_load_o, .soc_load_value_o, .discharge_overcurrent_i, .charge_overcurrent_i,
  .cell_comm_ok_i, .prot_clear_i);
`default_nettype wire

/* File: verification/bpd_plant.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Far side: cell modules, current sensor and charger. Acquisition adds
// one cycle, so the supervisor never sees a change in the launch cycle.
// ----------------------------------------------------------------------
module bpd_plant
  import bpd_pkg::*;
(
  // Clock.
  input  wire logic       clk_sys_i,
  // Commanded plant state.
  input  wire bpd_meas_s  meas_cmd_i,
  input  wire logic [5:0] cond_cmd_i,
  // Values seen by the supervisor.
  output var bpd_meas_s   meas_o,
  output var logic [5:0]  cond_o
);
  // Refresh the measurements once per cycle.
  always @(posedge clk_sys_i)
  begin
    meas_o <= meas_cmd_i;
    cond_o <= cond_cmd_i;
  end
endmodule // bpd_plant
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
  import bpd_pkg::*;
();
  // ----------------------------------------------------------------------
  // Signals. cond bits: 0 doc, 1 coc, 2 hdr, 3 comm ok, 4 charger, 5 done.
  // ----------------------------------------------------------------------
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, prot_clear = 1'b0, prot_en = 1'b1;
  bpd_param_req_s req = '0;
  bpd_meas_s mcmd = '{8'h80, 8'h80, 8'h60, 16'h2000}, meas;
  logic [5:0] ccmd = 6'h08, cond;
  logic [15:0] rdata;
  logic ack, err, copen, cstop, fault, clim, rst_p, soc_p;
  logic [7:0] soc_v;
  bpd_flags_s flags;
  logic [8:0] fl;
  int miscompares = 0, num_checks = 0, cyc = 0;
  logic [7:0] act_off [9] = '{8'h25, 8'h27, 8'h29, 8'h2B, 8'h2D, 8'h2F, 8'h34, 8'h36, 8'h38};
  logic [15:0] thr [10] = '{16'h0420, 16'h3140, 16'h05C0, 16'h32A0, 16'h0690,
                            16'h3380, 16'h0830, 16'h3A50, 16'h1588, 16'h3B78};
  assign fl = flags;
  always #10 clk_sys_i = ~clk_sys_i;
  bpd_plant u_plant (.clk_sys_i(clk_sys_i), .meas_cmd_i(mcmd), .cond_cmd_i(ccmd),
    .meas_o(meas), .cond_o(cond));
  // Tenth tick shortened to 4 cycles, so one second is 40 cycles.
  bpd_supervisor #(.TENTH_CYCLES(4)) uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .param_req_i(req), .param_rdata_o(rdata), .param_ack_o(ack), .param_err_o(err),
    .meas_i(meas), .discharge_overcurrent_i(cond[0]), .charge_overcurrent_i(cond[1]),
    .high_discharge_i(cond[2]), .cell_comm_ok_i(cond[3]), .charger_connected_i(cond[4]),
    .charge_finished_i(cond[5]), .contactor_prot_en_i(prot_en), .prot_clear_i(prot_clear),
    .flags_o(flags), .contactor_open_o(copen), .charge_stop_o(cstop), .fault_o(fault),
    .climate_stop_o(clim), .charge_restart_o(rst_p), .soc_load_o(soc_p),
    .soc_load_value_o(soc_v));
  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One request pulse; the answer is sampled just after the taking edge.
  task automatic bus(input logic w, input logic [15:0] a, d, ed, input logic ee);
    @(posedge clk_sys_i);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys_i);
    req <= '0;
    #1;
    chk(ack, 16'h1, "ack");
    chk(err, ee, "err");
    if (!w) chk(rdata, ed, "read data");
  endtask
  // Waits for a flag level and checks that the wait fell inside lo..hi cycles.
  task automatic wflag(input int ch, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (fl[ch] !== v && n <= hi)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(n >= lo && n <= hi, 16'h1, "delay window");
  endtask
  task automatic cond_set(input int ch, input logic on);
    @(posedge clk_sys_i);
    case (ch)
      0: mcmd.min_cell_v <= on ? 8'h10 : 8'h80;
      1: mcmd.max_cell_v <= on ? 8'hD0 : 8'h80;
      2, 7: mcmd.max_module_t <= on ? 8'hA0 : 8'h60;
      3: ccmd[0] <= on;
      4: ccmd[1] <= on;
      5: ccmd[3] <= !on;
      6: mcmd.min_cell_v <= on ? 8'h28 : 8'h80;
      default: ccmd[2] <= on;
    endcase
  endtask
  task automatic pulses(input logic sel, output int n);
    n = 0;
    repeat (6)
    begin
      @(posedge clk_sys_i);
      #1;
      n += sel ? soc_p : rst_p;
    end
  endtask
  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_regs();
    chk(fl, 16'h0, "flags after reset");
    bus(0, 16'h0025, 16'h0, 16'h0, 0);
    for (int a = 16'h25; a <= 16'h3B; a++)
    begin
      bus(1, a[15:0], a[15:0], 16'h0, 0);
      bus(0, a[15:0], 16'h0, a[15:0], 0);
    end
    bus(1, 16'h0118, 16'hABCD, 16'h0, 0);
    bus(0, 16'h0118, 16'h0, 16'hABCD, 0);
    bus(0, 16'h0100, 16'h0, 16'h0, 1);
    bus(1, 16'h0F00, 16'h1, 16'h0, 1);
  endtask
  task automatic t_chan();
    foreach (thr[i]) bus(1, {8'h00, thr[i][15:8]}, {8'h00, thr[i][7:0]}, 16'h0, 0);
    // Drop flags raised by zero thresholds.
    foreach (act_off[c]) bus(1, {8'h00, act_off[c] + 8'h01}, 16'h0, 16'h0, 0);
    for (int c = 0; c < 9; c++)
    begin
      bus(1, {8'h00, act_off[c]}, 16'h2, 16'h0, 0);
      bus(1, {8'h00, act_off[c] + 8'h01}, 16'h2, 16'h0, 0);
      cond_set(c, 1);
      wflag(c, 1, 4, 12);
      if (c == 0) chk(copen, 16'h1, "contactor");
      if (c == 2) chk({cstop, fault}, 16'h3, "heat stop");
      cond_set(c, 0);
      wflag(c, 0, 40, 84);
    end
  endtask
  // Between the two thresholds the under-voltage flag must hold.
  task automatic t_hyst();
    bus(1, 16'h0025, 16'h0, 16'h0, 0);
    bus(1, 16'h0026, 16'h0, 16'h0, 0);
    cond_set(0, 1);
    wflag(0, 1, 0, 6);
    @(posedge clk_sys_i);
    mcmd.min_cell_v <= 8'h30;
    repeat (60) @(posedge clk_sys_i);
    chk(fl[0], 16'h1, "held in band");
    prot_en <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(copen, 16'h0, "contactor disabled");
    @(posedge clk_sys_i) prot_en <= 1'b1;
    cond_set(0, 0);
    wflag(0, 0, 0, 6);
  endtask
  // Short bursts must not add up across a gap.
  task automatic t_glitch();
    bus(1, 16'h002B, 16'h3, 16'h0, 0);
    cond_set(3, 1);
    repeat (8) @(posedge clk_sys_i);
    cond_set(3, 0);
    @(posedge clk_sys_i);
    cond_set(3, 1);
    repeat (8) @(posedge clk_sys_i);
    cond_set(3, 0);
    #1;
    chk(fl[3], 16'h0, "burst ignored");
  endtask
  task automatic t_clear();
    bus(1, 16'h002B, 16'h0, 16'h0, 0);
    cond_set(3, 1);
    wflag(3, 1, 0, 6);
    @(posedge clk_sys_i);
    prot_clear <= 1'b1;
    @(posedge clk_sys_i);
    prot_clear <= 1'b0;
    ccmd[0] <= 1'b0;
    #1;
    chk(fl[3], 16'h0, "cleared");
    bus(0, 16'h002C, 16'h0, 16'h2, 0);
  endtask
  task automatic t_events();
    int n;
    bus(1, 16'h0118, 16'h0FA0, 16'h0, 0);
    @(posedge clk_sys_i) mcmd.soc <= 16'h0FA0;
    repeat (3) @(posedge clk_sys_i);
    chk(clim, 16'h0, "equal soc");
    mcmd.soc <= 16'hFF00;
    repeat (3) @(posedge clk_sys_i);
    chk(clim, 16'h1, "negative soc");
    bus(1, 16'h001A, 16'h78, 16'h0, 0);
    @(posedge clk_sys_i) ccmd[5:4] <= 2'b11;
    pulses(0, n);
    chk(n, 16'h0, "no restart");
    @(posedge clk_sys_i) mcmd.max_cell_v <= 8'h78;
    pulses(0, n);
    chk(n, 16'h1, "restart");
    bus(1, 16'h0022, 16'h55, 16'h0, 0);
    @(posedge clk_sys_i) mcmd.min_cell_v <= 8'h30;
    pulses(1, n);
    chk(n, 16'h1, "soc load");
    chk(soc_v, 16'h55, "soc value");
  endtask
  // ----------------------------------------------------------------------
  // Hang guard and main sequence.
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_chan();
    t_hyst();
    t_glitch();
    t_clear();
    t_events();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
